/* File: eozf_pkg.sv */
// package for the endpoint zero out-transfer success flag block
// assumes one 125 MHz clock and an active-low asynchronous reset
package eozf_pkg;
   // ----------------------------------------
   // register layout and reset values
   // ----------------------------------------
   localparam int OK_FLAG_BIT = 0;
   localparam logic OK_FLAG_RESET = 1'b0;
   localparam logic FAIL_FLAG_RESET = 1'b0;
   localparam logic [7:0] STATUS_RESET = 8'h00;

   // ----------------------------------------
   // event carrier from the transaction engine
   // ----------------------------------------
   typedef struct packed {
      logic setup_token;
      logic out_ack;
      logic setup_ack;
      logic setup_needs_cpu;
   } eozf_evt_type;

   // software access to one flag bit: the ok status bit, or the fail flag that has no status bit
   typedef struct packed {
      logic rd;
      logic wr;
      logic wr_data;
   } eozf_cpu_type;

   typedef enum logic [1:0] {
      EOZF_IDLE = 2'b00,
      EOZF_ARMED = 2'b01
   } eozf_clr_state_type;
endpackage

/* File: eozf_clear_guard.sv */
// read-then-write-zero guard for one software-cleared flag
// assumes cpu strobes are synchronous one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
module eozf_clear_guard (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic flag,
   input wire eozf_pkg::eozf_cpu_type cpu,
   output logic clear_ok
);
   typedef struct packed {
      eozf_pkg::eozf_clr_state_type st;
   } eozf_guard_type;

   eozf_guard_type state;
   eozf_guard_type next_state;

   // clear allowed only once the flag has been seen as one
   assign clear_ok = cpu.wr && !cpu.wr_data && (state.st == eozf_pkg::EOZF_ARMED);

   always_comb begin
      next_state = state;
      case (state.st)
         eozf_pkg::EOZF_IDLE: begin
            if (cpu.rd && flag) begin
               next_state.st = eozf_pkg::EOZF_ARMED;
            end
         end
         default: begin
            // any write consumes the arming; a flag dropped by hardware disarms too
            if (cpu.wr || !flag) begin
               next_state.st = eozf_pkg::EOZF_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state <= '{st: eozf_pkg::EOZF_IDLE};
      end else begin
         state <= next_state;
      end
   end
endmodule
`default_nettype wire

/* File: eozf_top.sv */
// endpoint zero out-transfer success flag with its failure flag partner
// assumes transaction events are one-cycle pulses on the system clock
`timescale 1ns/1ps
`default_nettype none
module eozf_top (
   input wire logic clock,
   input wire logic rst_n,
   input wire eozf_pkg::eozf_evt_type evt,
   input wire logic setup_intercept_bit,
   input wire eozf_pkg::eozf_cpu_type cpu,
   input wire eozf_pkg::eozf_cpu_type fail_cpu,
   output logic [7:0] status_reg,
   output logic ep_zero_out_ok_flag,
   output logic ep_zero_out_fail_flag
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef struct packed {
      logic ok;
      logic fail;
   } eozf_state_type;

   eozf_state_type state;
   eozf_state_type next_state;
   logic ok_clear;
   logic fail_clear;
   logic set_ok;
   logic set_fail;
   logic setup_for_cpu;
   logic setup_for_core;
   logic setup_blocked;

   // each flag keeps its own guard so a read of one never arms the other
   eozf_clear_guard ok_guard (
      .clock(clock),
      .rst_n(rst_n),
      .flag(state.ok),
      .cpu(cpu),
      .clear_ok(ok_clear)
   );

   eozf_clear_guard fail_guard (
      .clock(clock),
      .rst_n(rst_n),
      .flag(state.fail),
      .cpu(fail_cpu),
      .clear_ok(fail_clear)
   );

   // ----------------------------------------
   // set and clear conditions
   // ----------------------------------------
   // intercept mode hands every setup command to firmware, so its setup ack may set neither flag
   always_comb begin
      setup_for_cpu = evt.setup_ack && evt.setup_needs_cpu && !setup_intercept_bit;
      setup_for_core = evt.setup_ack && !evt.setup_needs_cpu && !setup_intercept_bit;
      setup_blocked = evt.setup_ack && setup_intercept_bit;
   end

   always_comb begin
      set_ok = evt.out_ack || setup_for_cpu;
      set_fail = setup_for_core;
   end

   always_comb begin
      next_state = state;
      // setup token and software clear lose to a same-cycle set
      if (evt.setup_token || ok_clear) begin
         next_state.ok = 1'b0;
      end
      if (set_ok) begin
         next_state.ok = 1'b1;
      end
      if (fail_clear) begin
         next_state.fail = 1'b0;
      end
      if (set_fail) begin
         next_state.fail = 1'b1;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state <= '{ok: eozf_pkg::OK_FLAG_RESET, fail: eozf_pkg::FAIL_FLAG_RESET};
      end else begin
         state <= next_state;
      end
   end

   // the other bits belong to other endpoints and read as zero here
   always_comb begin
      status_reg = eozf_pkg::STATUS_RESET;
      status_reg[eozf_pkg::OK_FLAG_BIT] = state.ok;
   end

   assign ep_zero_out_ok_flag = state.ok;
   assign ep_zero_out_fail_flag = state.fail;

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   out_ack_sets_a: assert property (evt.out_ack |=> ep_zero_out_ok_flag)
      else $error("out ack did not set ok flag");
   cpu_setup_sets_a: assert property (evt.setup_ack && evt.setup_needs_cpu && !setup_intercept_bit
      |=> ep_zero_out_ok_flag && !$past(set_fail))
      else $error("cpu setup did not set ok flag");
   core_setup_fail_a: assert property (evt.setup_ack && !evt.setup_needs_cpu && !setup_intercept_bit
      && !evt.out_ack |=> ep_zero_out_fail_flag)
      else $error("core setup did not set fail flag");
   intercept_quiet_a: assert property (setup_intercept_bit && evt.setup_ack && !evt.out_ack
      && !state.fail && (evt.setup_token || !state.ok) |=> !ep_zero_out_ok_flag && !ep_zero_out_fail_flag)
      else $error("intercept bit did not block flags");
   blind_clear_a: assert property (state.ok && !set_ok && cpu.wr && !cpu.wr_data && !evt.setup_token
      && $past(cpu.wr) && !$past(cpu.rd)
      |=> ep_zero_out_ok_flag)
      else $error("zero write without read cleared flag");
   read_clear_a: assert property (state.ok && cpu.rd ##1 cpu.wr && !cpu.wr_data && !set_ok && state.ok
      |=> !ep_zero_out_ok_flag)
      else $error("read then zero write did not clear");
   setup_clears_a: assert property (evt.setup_token && !set_ok |=> !ep_zero_out_ok_flag)
      else $error("setup token did not clear ok flag");
   status_bit_a: assert property (status_reg == {7'h00, ep_zero_out_ok_flag})
      else $error("status register layout wrong");
   set_wins_a: assert property ((ok_clear || evt.setup_token) && set_ok |=> ep_zero_out_ok_flag)
      else $error("clear beat a set");

   // ----------------------------------------
   // flag causes and holding
   // ----------------------------------------
   reset_clean_a: assert property ($rose(rst_n)
      |-> !ep_zero_out_ok_flag && !ep_zero_out_fail_flag && status_reg == eozf_pkg::STATUS_RESET)
      else $error("flags not clear after reset");
   status_upper_a: assert property (status_reg[7:1] == 7'h00)
      else $error("status register upper bits not zero");
   ok_stands_a: assert property (ep_zero_out_ok_flag && !ok_clear && !evt.setup_token
      |=> ep_zero_out_ok_flag)
      else $error("ok flag dropped without a clear");
   ok_no_stray_a: assert property (!ep_zero_out_ok_flag && !evt.out_ack
      && !(evt.setup_ack && evt.setup_needs_cpu && !setup_intercept_bit)
      |=> !ep_zero_out_ok_flag)
      else $error("ok flag set without a cause");
   ok_rise_cause_a: assert property ($rose(ep_zero_out_ok_flag)
      |-> $past(evt.out_ack) || $past(evt.setup_ack && evt.setup_needs_cpu && !setup_intercept_bit))
      else $error("ok flag rose without a completion");
   ok_fall_cause_a: assert property ($fell(ep_zero_out_ok_flag)
      |-> $past(evt.setup_token) || $past(ok_clear))
      else $error("ok flag fell without a clear");
   core_ok_quiet_a: assert property (evt.setup_ack && !evt.setup_needs_cpu && !evt.out_ack
      && (evt.setup_token || !ep_zero_out_ok_flag)
      |=> !ep_zero_out_ok_flag)
      else $error("core setup set ok flag");
   cpu_no_fail_a: assert property (evt.setup_ack && evt.setup_needs_cpu && !ep_zero_out_fail_flag
      |=> !ep_zero_out_fail_flag)
      else $error("cpu setup set fail flag");
   intercept_ok_a: assert property (setup_intercept_bit && evt.setup_ack && !evt.out_ack
      && !ep_zero_out_ok_flag
      |=> !ep_zero_out_ok_flag)
      else $error("intercepted setup set ok flag");
   intercept_fail_a: assert property (setup_intercept_bit && evt.setup_ack && !ep_zero_out_fail_flag
      |=> !ep_zero_out_fail_flag)
      else $error("intercepted setup set fail flag");
   write_one_a: assert property (ep_zero_out_ok_flag && cpu.wr && cpu.wr_data && !evt.setup_token
      |=> ep_zero_out_ok_flag)
      else $error("one write cleared ok flag");
   read_keeps_a: assert property (ep_zero_out_ok_flag && cpu.rd && !cpu.wr && !evt.setup_token
      |=> ep_zero_out_ok_flag)
      else $error("read alone cleared ok flag");
   token_only_a: assert property (evt.setup_token && !evt.out_ack && !evt.setup_ack
      |=> !ep_zero_out_ok_flag)
      else $error("setup token left ok flag set");
   fail_stands_a: assert property (ep_zero_out_fail_flag && !fail_clear
      |=> ep_zero_out_fail_flag)
      else $error("fail flag dropped without a clear");
   fail_no_stray_a: assert property (!ep_zero_out_fail_flag
      && !(evt.setup_ack && !evt.setup_needs_cpu && !setup_intercept_bit)
      |=> !ep_zero_out_fail_flag)
      else $error("fail flag set without a cause");
   fail_rise_cause_a: assert property ($rose(ep_zero_out_fail_flag)
      |-> $past(evt.setup_ack && !evt.setup_needs_cpu && !setup_intercept_bit))
      else $error("fail flag rose without a core setup");
   fail_fall_cause_a: assert property ($fell(ep_zero_out_fail_flag)
      |-> $past(fail_clear))
      else $error("fail flag fell without a clear");
   fail_read_clear_a: assert property (ep_zero_out_fail_flag && fail_cpu.rd
      ##1 fail_cpu.wr && !fail_cpu.wr_data && !set_fail && ep_zero_out_fail_flag
      |=> !ep_zero_out_fail_flag)
      else $error("fail flag read then zero write did not clear");
   // a write one cycle earlier always disarms, so this zero write is a blind one
   fail_blind_clear_a: assert property (ep_zero_out_fail_flag && !set_fail && fail_cpu.wr
      && !fail_cpu.wr_data && $past(fail_cpu.wr) && !$past(fail_cpu.rd)
      |=> ep_zero_out_fail_flag)
      else $error("fail flag blind write cleared it");
   fail_set_wins_a: assert property (fail_clear && set_fail |=> ep_zero_out_fail_flag)
      else $error("clear beat a fail set");
   setup_keeps_fail_a: assert property (evt.setup_token && ep_zero_out_fail_flag && !fail_clear
      |=> ep_zero_out_fail_flag)
      else $error("setup token touched fail flag");
   clear_isolated_a: assert property (ok_clear && ep_zero_out_fail_flag && !fail_clear
      |=> ep_zero_out_fail_flag)
      else $error("ok clear touched fail flag");
   ok_survives_a: assert property (fail_clear && ep_zero_out_ok_flag && !ok_clear
      && !evt.setup_token |=> ep_zero_out_ok_flag)
      else $error("fail clear touched ok flag");

   out_done_c: cover property (evt.out_ack ##1 cpu.rd ##1 cpu.wr && !cpu.wr_data ##1 !ep_zero_out_ok_flag);
   cpu_setup_c: cover property (evt.setup_token ##[1:4] evt.setup_ack && evt.setup_needs_cpu);
   core_setup_c: cover property (evt.setup_ack && !evt.setup_needs_cpu && !setup_intercept_bit);
   intercept_c: cover property (setup_intercept_bit && evt.setup_ack);
   blocked_c: cover property (setup_blocked && evt.setup_needs_cpu);
endmodule
`default_nettype wire

/* File: eozf_host_model.sv */
// usb host stand-in that launches endpoint zero transaction events
// assumes req is set up by the bench half a cycle before launch
`timescale 1ns/1ps
`default_nettype none
module eozf_host_model (
   input wire logic clock,
   input wire eozf_pkg::eozf_evt_type req,
   output var eozf_pkg::eozf_evt_type evt
);
   // ----------------------------------------
   // event launch
   // ----------------------------------------
   initial evt = '0;
   // qualifier means nothing without setup_ack, so it toggles every cycle that setup_ack is low
   always @(negedge clock) begin
      evt <= '{setup_token: req.setup_token, out_ack: req.out_ack, setup_ack: req.setup_ack,
         setup_needs_cpu: req.setup_ack ? req.setup_needs_cpu : ~evt.setup_needs_cpu};
   end
endmodule
`default_nettype wire

/* File: test_ep0_out_success_flag.sv */
// self-checking bench for the endpoint zero out success flag
// assumes the host model file and the design files are compiled first
`timescale 1ns/1ps
`default_nettype none
module test_ep0_out_success_flag;
   logic clock, rst_n, ib, e_ok, e_fail, arm, farm;
   eozf_pkg::eozf_evt_type req, evt;
   eozf_pkg::eozf_cpu_type cpu, fail_cpu;
   logic [7:0] status_reg;
   logic ok, fail;
   int fails = 0, tests_run = 0, seed = 8;
   logic [9:0] dir [12] = '{10'h100, 10'h008, 10'h010, 10'h008, 10'h100, 10'h200,
      10'h0E0, 10'h080, 10'h0C0, 10'h012, 10'h109, 10'h300};
   eozf_host_model host (.clock(clock), .req(req), .evt(evt));
   eozf_top DUT (.clock(clock), .rst_n(rst_n), .evt(evt), .setup_intercept_bit(ib), .cpu(cpu),
      .fail_cpu(fail_cpu), .status_reg(status_reg), .ep_zero_out_ok_flag(ok), .ep_zero_out_fail_flag(fail));
   // ----------------------------------------
   // expectation model
   // ----------------------------------------
   function automatic logic nxt(input logic f, input logic s, input logic c);
      return s ? 1'b1 : (c ? 1'b0 : f);
   endfunction
   function automatic logic guard(input logic a, input logic f, input eozf_pkg::eozf_cpu_type c);
      return c.wr ? 1'b0 : ((c.rd & f) ? 1'b1 : (a & f));
   endfunction
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         {e_ok, e_fail, arm, farm} <= 4'h0;
      end else begin
         e_ok <= nxt(e_ok, evt.out_ack | (evt.setup_ack & evt.setup_needs_cpu & !ib),
            evt.setup_token | (arm & cpu.wr & !cpu.wr_data));
         e_fail <= nxt(e_fail, evt.setup_ack & !evt.setup_needs_cpu & !ib,
            farm & fail_cpu.wr & !fail_cpu.wr_data);
         arm <= guard(arm, e_ok, cpu);
         farm <= guard(farm, e_fail, fail_cpu);
      end
   end
   // ----------------------------------------
   // comparison, drive and closing
   // ----------------------------------------
   task check(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task check_all;
      check(ok, e_ok);
      check(fail, e_fail);
      check(status_reg, {7'h00, e_ok});
   endtask
   // read and write never share a cycle, as a set read bit suppresses the write
   task apply(input logic [9:0] v);
      // req leads by half a cycle so the host launches it with the cpu strobes
      @(posedge clock);
      req <= v[9:6];
      @(negedge clock);
      ib <= v[5];
      cpu <= {v[4], v[3] & !v[4], v[2]};
      fail_cpu <= {v[1], v[0] & !v[1], 1'b0};
   endtask
   task report_and_stop;
      $display("comparisons %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   initial begin
      #20000;
      fails++;
      report_and_stop;
   end
   initial begin
      rst_n = 1'b0;
      {req, ib, cpu, fail_cpu} = '0;
      repeat (10) @(negedge clock);
      check_all;
      rst_n = 1'b1;
      foreach (dir[i]) begin
         apply(dir[i]);
         check_all;
      end
      repeat (1500) begin
         apply(10'($random(seed)));
         check_all;
      end
      apply(10'h000);
      check_all;
      report_and_stop;
   end
endmodule
`default_nettype wire
